/* design/rld_pkg.sv */
package rld_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [7:0] RLD_CMD_ADDR = 8'h00;
	localparam logic [7:0] RLD_STAT_ADDR = 8'h04;
	localparam logic [7:0] RLD_CFG_ADDR = 8'h08;
	localparam logic [7:0] RLD_DESC_ADDR = 8'h0C;
	localparam logic [7:0] RLD_RXSTAT_ADDR = 8'h10;
	localparam logic [7:0] RLD_FRAME_ADDR = 8'h14;
	// ----------------------------------------
	// command bits
	// ----------------------------------------
	localparam int RLD_CMD_QUEUE = 0;
	localparam int RLD_CMD_ADVANCE = 1;
	localparam int RLD_CMD_HALT = 2;
	// ----------------------------------------
	// status bits
	// ----------------------------------------
	localparam int RLD_ST_QUEUE_ARMED = 0;
	localparam int RLD_ST_HDR_DONE = 1;
	localparam int RLD_ST_COPY_DONE = 2;
	localparam int RLD_ST_QEMPTY = 3;
	localparam int RLD_ST_COPY_PROG = 4;
	localparam int RLD_ST_BUF_EMPTY = 5;
	localparam int RLD_ST_QUIET = 6;
	localparam int RLD_ST_NET_VALID = 7;
	// ----------------------------------------
	// descriptor control and status words
	// ----------------------------------------
	localparam int RLD_DC_HEADER = 18;
	localparam int RLD_DC_FRAGLIST = 16;
	localparam int RLD_DC_LEN_MSB = 15;
	localparam int RLD_DS_OWN = 31;
	localparam int RLD_DS_NET_VALID = 12;
	// ----------------------------------------
	// burst control
	// ----------------------------------------
	localparam logic [1:0] RLD_BURST_RESET = 2'h0;
	localparam int RLD_BURST_UNIT_BYTES = 32;
	localparam logic [31:0] RLD_DESC_RESET = 32'h0000_0000;
	typedef enum logic [3:0] {
		RLD_IDLE, RLD_FETCH, RLD_WAIT_FRAME, RLD_COPY, RLD_NEXT_FRAG, RLD_POST
	} rld_state_type;
endpackage

/* design/rld_rx_lookahead_dma.sv */
// Summary of operation
// RULE1: driver queues header descriptor, then arms queue
// RULE2: header copy stops at buffer full/frame end
// RULE3: post status, raise header-done after header copy
// RULE4: net status valid only once reception finished
// RULE5: after header copy disarm queue, raise empty
// RULE6: rearm without advance recopies current frame
// RULE7: fragment copy starts at offset byte
// RULE8: nonzero offset waits for complete frame
// RULE9: after copy post, signal, fetch next descriptor
// RULE10: advance-frame discards frame, next is header
// RULE11: advance with host-owned next updates status
// RULE12: advance may follow arm for one copy
// RULE13: advance at most once per frame
// RULE14: halt clears armed; finish copy then idle
// RULE15: quiet only when receiver and dma idle
// RULE16: host-owned mid-copy: empty, idle, resume later
// RULE17: copy-in-progress and buffer-empty status visible
// RULE18: halt without frames rewinds descriptor pointer
// RULE19: frames and fragments up to 64 Kbytes
// RULE20: burst at threshold, ends empty or lost
// RULE21: rebursts at threshold or final data loaded
// RULE22: burst select 32/64/96/128 byte thresholds
// RULE23: control bit18 header, bit16 fraglist, 15:0 length
// RULE24: ownership 1 accepts, follows next pointer
// RULE25: burst select is writable, resets lowest
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module rld_rx_lookahead_dma import rld_pkg::*; #(
	parameter int FIFO_BYTES = 128,
	parameter int LEN_W = 16
) (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// local receive ram (same clock)
	input wire logic frame_ready,
	input wire logic frame_complete,
	input wire logic [LEN_W-1:0] frame_length,
	input wire logic [15:0] frame_net_status,
	input wire logic [31:0] ram_data,
	output logic [LEN_W-1:0] ram_index,
	output logic frame_release,
	input wire logic receiver_idle,
	// host memory master (simple request/grant)
	output logic mem_req,
	output logic mem_write,
	output logic [31:0] mem_addr,
	output logic [31:0] mem_wdata,
	input wire logic mem_gnt,
	input wire logic mem_rvalid,
	input wire logic [31:0] mem_rdata,
	output logic burst_active
);
	// ----------------------------------------
	// registers
	// ----------------------------------------
	rld_state_type state;
	logic queue_armed, advance_frame, halt_receive_dma;
	logic header_done_irq, copy_complete_irq, queue_empty_irq, net_status_valid;
	logic copy_in_progress;
	logic [1:0] burst_level_select;
	logic [31:0] desc_ptr, desc_saved, rx_status_register;
	logic [31:0] buf_addr, next_ptr;
	logic [2:0] fetch_word;
	logic desc_header, desc_frag, have_desc, read_pending;
	logic [LEN_W-1:0] buf_len, copy_pos, desc_offset;
	logic [LEN_W-1:0] done_bytes;
	logic [31:0] post_addr;
	logic set_q, set_adv, set_halt;
	logic apb_wr;
	logic [7:0] fifo_fill;
	logic [7:0] thresh;
	logic post_hdr;
	logic clr_armed_hw, beat_taken, fetch_wait, beat_gap;
	logic [31:0] frag_ptr;
	// a beat counts only when our own request meets the grant
	assign beat_taken = mem_req && mem_gnt;
	assign apb_wr = psel && penable && pwrite;
	assign set_q = apb_wr && paddr == RLD_CMD_ADDR && pwdata[RLD_CMD_QUEUE];
	assign set_adv = apb_wr && paddr == RLD_CMD_ADDR && pwdata[RLD_CMD_ADVANCE];
	assign set_halt = apb_wr && paddr == RLD_CMD_ADDR && pwdata[RLD_CMD_HALT];
	// RULE22: threshold decode
	assign thresh = 8'((32'(burst_level_select) + 32'd1) * RLD_BURST_UNIT_BYTES);
	// ----------------------------------------
	// apb
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable && !pwrite) begin
				if (paddr == RLD_STAT_ADDR) begin
					prdata <= {24'h000000, net_status_valid,
						// RULE15: quiet needs receiver and dma idle
						receiver_idle && state == RLD_IDLE && !copy_in_progress,
						// RULE17: visible progress flags
						!frame_ready, copy_in_progress, queue_empty_irq,
						copy_complete_irq, header_done_irq, queue_armed};
				end else if (paddr == RLD_CFG_ADDR) begin
					prdata <= {30'h0, burst_level_select};
				end else if (paddr == RLD_DESC_ADDR) begin
					prdata <= desc_ptr;
				end else if (paddr == RLD_RXSTAT_ADDR) begin
					prdata <= rx_status_register;
				end else if (paddr == RLD_FRAME_ADDR) begin
					prdata <= {16'h0000, 16'(frame_length)};
				end else begin
					prdata <= 32'h0000_0000;
				end
			end
			if (psel && !penable && paddr > RLD_FRAME_ADDR) begin
				pslverr <= 1'b1;
			end
		end
	end
	// RULE25: software burst select, resets lowest
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			burst_level_select <= RLD_BURST_RESET;
		end else if (apb_wr && paddr == RLD_CFG_ADDR) begin
			burst_level_select <= pwdata[1:0];
		end
	end
	// ----------------------------------------
	// flags (hardware set wins over clear)
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			header_done_irq <= 1'b0;
			copy_complete_irq <= 1'b0;
			queue_empty_irq <= 1'b0;
		end else begin
			if (apb_wr && paddr == RLD_STAT_ADDR) begin
				header_done_irq <= header_done_irq & ~pwdata[RLD_ST_HDR_DONE];
				copy_complete_irq <= copy_complete_irq & ~pwdata[RLD_ST_COPY_DONE];
				queue_empty_irq <= queue_empty_irq & ~pwdata[RLD_ST_QEMPTY];
			end
			// RULE3: header-done raised on header post
			if (state == RLD_POST && beat_taken && post_hdr) begin
				header_done_irq <= 1'b1;
			end
			// RULE9: copy-complete on ordinary post
			if (state == RLD_POST && beat_taken && !post_hdr) begin
				copy_complete_irq <= 1'b1;
			end
			// RULE5: queue empty on hardware disarm events (header post, host-owned descriptor), not on halt
			if (clr_armed_hw) begin
				queue_empty_irq <= 1'b1;
			end
		end
	end
	assign clr_armed_hw = (state == RLD_POST && beat_taken && post_hdr)
		|| (state == RLD_FETCH && mem_rvalid && fetch_wait && fetch_word == 3'd0
			&& !mem_rdata[RLD_DS_OWN]);
	// ----------------------------------------
	// command bits
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			queue_armed <= 1'b0;
			advance_frame <= 1'b0;
			halt_receive_dma <= 1'b0;
		end else begin
			// RULE14: halt forces armed low
			if (set_halt) begin
				queue_armed <= 1'b0;
			end else if (set_q) begin
				queue_armed <= 1'b1;
			end else if (clr_armed_hw) begin
				queue_armed <= 1'b0;
			end
			halt_receive_dma <= set_halt ? 1'b1 : (set_q ? 1'b0 : halt_receive_dma);
			// RULE10: advance recorded, consumed when frame released
			// RULE13: a second advance per frame is simply absorbed
			if (set_adv) begin
				advance_frame <= 1'b1;
			end else if (frame_release) begin
				advance_frame <= 1'b0;
			end
		end
	end
	// ----------------------------------------
	// dma sequencer
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= RLD_IDLE;
			desc_ptr <= RLD_DESC_RESET;
			desc_saved <= RLD_DESC_RESET;
			buf_addr <= 32'h0000_0000;
			next_ptr <= 32'h0000_0000;
			post_addr <= 32'h0000_0000;
			fetch_word <= 3'd0;
			desc_header <= 1'b0;
			desc_frag <= 1'b0;
			have_desc <= 1'b0;
			buf_len <= '0;
			desc_offset <= '0;
			copy_pos <= '0;
			done_bytes <= '0;
			copy_in_progress <= 1'b0;
			frame_release <= 1'b0;
			rx_status_register <= 32'h0000_0000;
			net_status_valid <= 1'b0;
			post_hdr <= 1'b0;
			fifo_fill <= 8'h00;
			read_pending <= 1'b0;
			fetch_wait <= 1'b0;
			frag_ptr <= 32'h0000_0000;
		end else begin
			frame_release <= 1'b0;
			case (state)
			RLD_IDLE: begin
				// RULE11: advance with no descriptor refreshes status
				if (advance_frame && !copy_in_progress && frame_ready && !read_pending) begin
					rx_status_register <= {16'(frame_length), 16'(frame_net_status)};
					frame_release <= 1'b1;
					done_bytes <= '0;
				end
				// RULE6: arm alone re-fetches for another copy
				if (queue_armed && !halt_receive_dma) begin
					state <= have_desc ? RLD_WAIT_FRAME : RLD_FETCH;
					fetch_word <= 3'd0;
				end
			end
			RLD_FETCH: begin
				// one read outstanding at a time keeps words in order
				if (beat_taken && !mem_write) begin
					fetch_wait <= 1'b1;
				end
				if (mem_rvalid && fetch_wait) begin
					fetch_wait <= 1'b0;
					fetch_word <= fetch_word + 3'd1;
					if (fetch_word == 3'd0) begin
						// RULE24: ownership decides accept or stop
						if (!mem_rdata[RLD_DS_OWN]) begin
							// RULE16: stop here, resume when rearmed
							state <= RLD_IDLE;
						end
					end else if (fetch_word == 3'd1) begin
						buf_addr <= mem_rdata;
					end else if (fetch_word == 3'd2) begin
						// RULE23: control word decode
						desc_header <= mem_rdata[RLD_DC_HEADER];
						desc_frag <= mem_rdata[RLD_DC_FRAGLIST];
						buf_len <= mem_rdata[RLD_DC_LEN_MSB:0];
						desc_offset <= mem_rdata[RLD_DC_FRAGLIST] ?
							mem_rdata[RLD_DC_LEN_MSB:0] : '0;
					end else if (fetch_word == 3'd3) begin
						next_ptr <= {mem_rdata[31:2], 2'b00};
						desc_saved <= desc_ptr;
						post_addr <= desc_ptr;
						desc_ptr <= {mem_rdata[31:2], 2'b00};
						have_desc <= 1'b1;
						frag_ptr <= buf_addr;
						if (!desc_frag) begin
							state <= copy_in_progress ? RLD_COPY : RLD_WAIT_FRAME;
						end
					end else if (fetch_word == 3'd4) begin
						// fragment entry: pointer first, length second only
						buf_addr <= mem_rdata;
					end else begin
						buf_len <= mem_rdata[RLD_DC_LEN_MSB:0];
						frag_ptr <= frag_ptr + 32'd8;
						state <= copy_in_progress ? RLD_COPY : RLD_WAIT_FRAME;
					end
				end
			end
			RLD_WAIT_FRAME: begin
				if (halt_receive_dma && !frame_ready) begin
					// RULE18: rewind to saved descriptor
					desc_ptr <= desc_saved;
					have_desc <= 1'b0;
					state <= RLD_IDLE;
				end else if (frame_ready && (!advance_frame || done_bytes == '0)) begin
					// RULE8: nonzero offset needs full frame
					if (desc_offset == '0 || frame_complete) begin
						// RULE7: start at offset byte
						copy_pos <= desc_offset;
						copy_in_progress <= 1'b1;
						state <= RLD_COPY;
					end
				end
			end
			RLD_COPY: begin
				// RULE20: fill continues while burst drains
				if (!read_pending && fifo_fill < 8'(FIFO_BYTES)
					&& copy_pos + LEN_W'(fifo_fill) < frame_length
					&& LEN_W'(fifo_fill) < buf_len) begin
					read_pending <= 1'b1;
				end
				if (read_pending) begin
					read_pending <= 1'b0;
					fifo_fill <= fifo_fill + 8'd4;
				end
				if (burst_active && beat_taken) begin
					buf_addr <= buf_addr + 32'd4;
					copy_pos <= copy_pos + LEN_W'(4);
					buf_len <= (buf_len > LEN_W'(4)) ? buf_len - LEN_W'(4) : '0;
					fifo_fill <= fifo_fill - 8'd4 + (read_pending ? 8'd4 : 8'd0);
				end
				// RULE2: stop when buffer full or frame done
				if (fifo_fill == 8'h00 && !read_pending
					&& (copy_pos >= frame_length || buf_len == '0)) begin
					if (copy_pos < frame_length && desc_frag) begin
						state <= RLD_NEXT_FRAG;
					end else begin
						post_hdr <= desc_header;
						state <= RLD_POST;
					end
				end
			end
			RLD_NEXT_FRAG: begin
				// next fragment list entry for more buffer space
				state <= RLD_FETCH;
				fetch_word <= 3'd4;
			end
			RLD_POST: begin
				if (beat_taken) begin
					// RULE4: network status valid only when frame complete
					net_status_valid <= frame_complete;
					rx_status_register <= {16'(frame_length), 16'(frame_net_status)};
					copy_in_progress <= 1'b0;
					have_desc <= 1'b0;
					done_bytes <= copy_pos;
					// RULE10: advanced frame is released here
					if (advance_frame) begin
						frame_release <= 1'b1;
					end
					// RULE5: header copy ends in idle
					// RULE9: otherwise fetch the next descriptor
					// RULE12: works even after advance
					state <= post_hdr ? RLD_IDLE : RLD_FETCH;
					fetch_word <= 3'd0;
				end
			end
			default: begin
				state <= RLD_IDLE;
			end
			endcase
		end
	end
	// ----------------------------------------
	// bus master drive
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			burst_active <= 1'b0;
			mem_req <= 1'b0;
			mem_write <= 1'b0;
			mem_addr <= 32'h0000_0000;
			mem_wdata <= 32'h0000_0000;
			ram_index <= '0;
			beat_gap <= 1'b0;
		end else begin
			// gap after a beat lets address and data catch up together
			beat_gap <= beat_taken;
			ram_index <= copy_pos;
			mem_wdata <= (state == RLD_POST) ?
				{16'(frame_length), 3'b0, frame_complete, frame_net_status[11:0]} : ram_data;
			if (state == RLD_COPY) begin
				// RULE21: start at threshold or when last data loaded
				if (!burst_active && fifo_fill != 8'h00
					&& (fifo_fill >= thresh || copy_pos + LEN_W'(fifo_fill) >= frame_length
					|| LEN_W'(fifo_fill) >= buf_len)) begin
					burst_active <= 1'b1;
				// RULE20: burst ends when fifo empties
				end else if (burst_active && fifo_fill <= 8'd4 && beat_taken) begin
					burst_active <= 1'b0;
				end
			end else begin
				burst_active <= 1'b0;
			end
			// lost grant keeps request up, so re-request is immediate
			mem_req <= !beat_taken && !beat_gap && ((state == RLD_FETCH && !fetch_wait)
				|| (state == RLD_POST) || burst_active);
			mem_write <= state != RLD_FETCH;
			mem_addr <= (state == RLD_FETCH) ? ((fetch_word < 3'd4)
				? desc_ptr + 32'(fetch_word) * 32'd4
				: frag_ptr + 32'(fetch_word - 3'd4) * 32'd4)
				: (state == RLD_POST) ? post_addr : buf_addr;
		end
	end
endmodule
`default_nettype wire

/* sim/rld_checker_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_checker import rld_pkg::*; (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	// register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// receive side and host bus
	input wire logic frame_ready,
	input wire logic receiver_idle,
	input wire logic frame_release,
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic mem_gnt,
	input wire logic burst_active
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	logic acc, rd_stat, halted;
	logic [1:0] cfg_copy;
	assign acc = psel && penable && pready;
	assign rd_stat = acc && !pwrite && paddr == RLD_STAT_ADDR;
	// ----------------------------------------
	// software-side shadows
	// ----------------------------------------
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			halted <= 1'b0;
			cfg_copy <= 2'h0;
		end else if (acc && pwrite && paddr == RLD_CMD_ADDR) begin
			halted <= pwdata[RLD_CMD_HALT] || (halted && !pwdata[RLD_CMD_QUEUE]);
		end else if (acc && pwrite && paddr == RLD_CFG_ADDR) begin
			cfg_copy <= pwdata[1:0];
		end
	end
	property p_ready_answer;
		psel && !penable |=> pready && penable;
	endproperty
	a_ready_answer: assert property (p_ready_answer) else $error("no ready in access cycle");
	property p_ready_single;
		pready |=> !pready;
	endproperty
	a_ready_single: assert property (p_ready_single) else $error("ready held too long");
	property p_refuse;
		acc |-> pslverr == (paddr > RLD_FRAME_ADDR);
	endproperty
	a_refuse: assert property (p_refuse) else $error("slave error flag wrong");
	property p_burst_cfg;
		acc && !pwrite && paddr == RLD_CFG_ADDR |-> prdata[1:0] == cfg_copy;
	endproperty
	a_burst_cfg: assert property (p_burst_cfg) else $error("burst level readback wrong");
	property p_halt_disarm;
		rd_stat && halted |-> !prdata[RLD_ST_QUEUE_ARMED];
	endproperty
	a_halt_disarm: assert property (p_halt_disarm) else $error("armed after halt");
	property p_quiet;
		rd_stat && !$past(receiver_idle) && !$past(receiver_idle, 2) |-> !prdata[RLD_ST_QUIET];
	endproperty
	a_quiet: assert property (p_quiet) else $error("quiet while receiver busy");
	property p_buf_empty;
		rd_stat && !$past(frame_ready) && !$past(frame_ready, 2) |-> prdata[RLD_ST_BUF_EMPTY];
	endproperty
	a_buf_empty: assert property (p_buf_empty) else $error("buffer empty flag low");
	property p_release_pulse;
		frame_release |=> !frame_release;
	endproperty
	a_release_pulse: assert property (p_release_pulse) else $error("release not a pulse");
	property p_mem_hold;
		mem_req && !mem_gnt |=> mem_req && $stable(mem_addr) && $stable(mem_write);
	endproperty
	a_mem_hold: assert property (p_mem_hold) else $error("host request dropped");
	property p_reset_idle;
		$rose(reset_n) |-> !mem_req && !burst_active && !frame_release && !pready;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("outputs busy after reset");
	c_halt: cover property (acc && pwrite && paddr == RLD_CMD_ADDR && pwdata[RLD_CMD_HALT]);
	c_write_beat: cover property (mem_req && mem_gnt && mem_write);
	c_release: cover property (frame_release);
endmodule
bind rld_rx_lookahead_dma rld_checker rld_checker_inst (
	.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .frame_ready, .receiver_idle, .frame_release, .mem_req, .mem_write,
	.mem_addr, .mem_gnt, .burst_active
);
`default_nettype wire

/* sim/rld_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_host_model (
	// system
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic slow,
	// host bus
	input wire logic mem_req,
	input wire logic mem_write,
	input wire logic [31:0] mem_addr,
	input wire logic [31:0] mem_wdata,
	output logic mem_gnt,
	output logic mem_rvalid,
	output logic [31:0] mem_rdata
);
	logic [31:0] mem [0:255];
	logic skip;
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 32'h5A5A_5A5A;
	end
	// slow mode takes the bus away
	assign mem_gnt = mem_req && !(slow && skip);
	always @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			skip <= 1'b0;
			mem_rvalid <= 1'b0;
			mem_rdata <= 32'h0000_0000;
		end else begin
			skip <= !skip;
			mem_rvalid <= mem_gnt && !mem_write;
			// idle data line keeps moving so stale data is never mistaken
			mem_rdata <= (mem_gnt && !mem_write) ? mem[mem_addr[9:2]] : ~mem_rdata;
			if (mem_gnt && mem_write) mem[mem_addr[9:2]] <= mem_wdata;
		end
	end
endmodule
`default_nettype wire

/* sim/rld_rx_lookahead_dma_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module rld_rx_lookahead_dma_bench import rld_pkg::*;;
	logic clk_sys, reset_n, psel, penable, pwrite, frame_ready, frame_complete;
	logic receiver_idle, slow, pready, pslverr, frame_release, mem_req, mem_write;
	logic mem_gnt, mem_rvalid, burst_active, last_err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, mem_addr, mem_wdata, mem_rdata, ram_data, q;
	logic [15:0] frame_length, frame_net_status, ram_index;
	int failures, samples_checked;
	int releases = 0;
	assign ram_data = {16'hF00D, ram_index};
	rld_rx_lookahead_dma rld_rx_lookahead_dma_inst (
		.clk_sys, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .frame_ready, .frame_complete, .frame_length, .frame_net_status,
		.ram_data, .ram_index, .frame_release, .receiver_idle, .mem_req, .mem_write,
		.mem_addr, .mem_wdata, .mem_gnt, .mem_rvalid, .mem_rdata, .burst_active
	);
	rld_host_model rld_host_model_inst (
		.clk_sys, .reset_n, .slow, .mem_req, .mem_write, .mem_addr, .mem_wdata,
		.mem_gnt, .mem_rvalid, .mem_rdata
	);
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) if (frame_release === 1'b1) releases <= releases + 1;
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic wrap_up();
		if (failures == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic fail(input string what);
		failures++;
		$display("ERROR %0t %s", $time, what);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		samples_checked++;
		if (got !== exp) fail(what);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_sys);
		if (n >= 50) begin
			fail("register access hang");
			wrap_up();
		end
	endtask
	// polls until every bit of m reads as one
	task automatic wait_reg(input logic [7:0] a, input logic [31:0] m);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((q & m) !== m && n < 300);
		if (n >= 300) begin
			fail("poll hang");
			wrap_up();
		end
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic test_regs();
		apb(1'b0, RLD_CFG_ADDR, 32'h0);
		chk(q & 32'h3, 32'h0, "burst level reset");
		apb(1'b0, RLD_STAT_ADDR, 32'h0);
		chk(q & 32'h71, 32'h60, "idle status");
		for (int i = 3; i >= 0; i--) begin
			apb(1'b1, RLD_CFG_ADDR, i);
			apb(1'b0, RLD_CFG_ADDR, 32'h0);
			chk(q & 32'h3, i, "burst level readback");
		end
		apb(1'b0, 8'h18, 32'h0);
		chk(last_err, 1'b1, "unmapped read accepted");
	endtask
	task automatic test_header();
		rld_host_model_inst.mem[0] = 32'h8000_0000;
		rld_host_model_inst.mem[1] = 32'h0000_0100;
		rld_host_model_inst.mem[2] = 32'h0004_0008;
		rld_host_model_inst.mem[3] = 32'h0000_0010;
		rld_host_model_inst.mem[4] = 32'h8000_0000;
		rld_host_model_inst.mem[5] = 32'h0000_0040;
		rld_host_model_inst.mem[6] = 32'h0001_0004;
		rld_host_model_inst.mem[7] = 32'h0000_0020;
		rld_host_model_inst.mem[8] = 32'h0000_0000;
		rld_host_model_inst.mem[16] = 32'h0000_0200;
		rld_host_model_inst.mem[17] = 32'h0000_0040;
		frame_ready <= 1'b1;
		frame_complete <= 1'b1;
		apb(1'b1, RLD_CMD_ADDR, 32'h1);
		wait_reg(RLD_STAT_ADDR, 32'h2);
		apb(1'b0, RLD_STAT_ADDR, 32'h0);
		chk(q & 32'h9, 32'h8, "armed after header");
		chk(rld_host_model_inst.mem[64], 32'hF00D_0000, "header data");
		chk(rld_host_model_inst.mem[66], 32'h5A5A_5A5A, "header overrun");
		chk(rld_host_model_inst.mem[0][12], 1'b1, "header net status");
	endtask
	task automatic test_recopy();
		slow <= 1'b1;
		apb(1'b1, RLD_STAT_ADDR, 32'hFF);
		apb(1'b1, RLD_CMD_ADDR, 32'h1);
		wait_reg(RLD_STAT_ADDR, 32'hC);
		apb(1'b0, RLD_STAT_ADDR, 32'h0);
		chk(q & 32'h9, 32'h8, "armed after copy");
		chk(rld_host_model_inst.mem[128], 32'hF00D_0004, "offset data");
		chk(rld_host_model_inst.mem[4][12], 1'b1, "copy status");
		slow <= 1'b0;
	endtask
	task automatic test_discard();
		apb(1'b1, RLD_STAT_ADDR, 32'hFF);
		apb(1'b1, RLD_CMD_ADDR, 32'h3);
		wait_reg(RLD_STAT_ADDR, 32'h8);
		chk(releases, 1, "frame not released");
		apb(1'b0, RLD_RXSTAT_ADDR, 32'h0);
		chk(q & 32'h7F, 32'h01, "receive status");
		frame_ready <= 1'b0;
	endtask
	task automatic test_halt();
		rld_host_model_inst.mem[8] = 32'h8000_0000;
		rld_host_model_inst.mem[10] = 32'h0004_0008;
		rld_host_model_inst.mem[11] = 32'h0000_0030;
		apb(1'b1, RLD_CMD_ADDR, 32'h1);
		wait_reg(RLD_DESC_ADDR, 32'h30);
		apb(1'b1, RLD_CMD_ADDR, 32'h4);
		apb(1'b0, RLD_DESC_ADDR, 32'h0);
		chk(q, 32'h20, "descriptor not rewound");
		receiver_idle <= 1'b0;
		repeat (3) @(posedge clk_sys);
		apb(1'b0, RLD_STAT_ADDR, 32'h0);
		chk(q & 32'h51, 32'h0, "halted status");
		receiver_idle <= 1'b1;
		repeat (3) @(posedge clk_sys);
		apb(1'b0, RLD_STAT_ADDR, 32'h0);
		chk(q[RLD_ST_QUIET], 1'b1, "quiet missing");
	endtask
	initial begin
		repeat (50000) @(posedge clk_sys);
		fail("run limit");
		wrap_up();
	end
	initial begin
		{reset_n, psel, penable, pwrite, frame_ready, frame_complete, slow} = 7'h00;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		receiver_idle = 1'b1;
		frame_length = 16'h0010;
		frame_net_status = 16'h0001;
		failures = 0;
		samples_checked = 0;
		repeat (20) @(posedge clk_sys);
		reset_n <= 1'b1;
		@(posedge clk_sys);
		test_regs();
		test_header();
		test_recopy();
		test_discard();
		test_halt();
		wrap_up();
	end
endmodule
`default_nettype wire
